//--- hw/rcil_pkg.sv
// constants and carrier types for the reset initial condition logic
`default_nettype none
package rcil_pkg;
  // clock and delay before a code-fault reset
  localparam int unsigned CLK_PERIOD_NS = 10;
  localparam int unsigned SRESET_NS     = 1000;
  localparam int unsigned SRESET_CYC    =
    (SRESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // register port widths
  localparam int unsigned ADDR_W = 3;
  localparam int unsigned DATA_W = 8;
  // register offsets
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 3'h0;
  localparam logic [ADDR_W-1:0] ADDR_WDOG_CTL  = 3'h1;
  localparam logic [ADDR_W-1:0] ADDR_RST_CAUSE = 3'h2;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_ST = 3'h3;
  localparam logic [ADDR_W-1:0] ADDR_IRQ_MK = 3'h4;
  // status bit positions
  localparam int unsigned ST_PWRDN  = 0;
  localparam int unsigned ST_EXPIRY = 1;
  // watchdog control fields and codes
  localparam int unsigned WE_HI = 7;
  localparam int unsigned WE_LO = 3;
  localparam int unsigned WS_HI = 2;
  localparam int unsigned WS_LO = 0;
  localparam logic [4:0] WE_ENABLE  = 5'h0A;
  localparam logic [4:0] WE_DISABLE = 5'h15;
  localparam logic [DATA_W-1:0] WDOG_CTL_POR = 8'h53;
  // reset cause flag bit
  localparam int unsigned RST_CAUSE_FAULT = 0;
  // interrupt event bits
  localparam int unsigned IRQ_W    = 4;
  localparam int unsigned IRQ_POR  = 0;
  localparam int unsigned IRQ_WDTN = 1;
  localparam int unsigned IRQ_WDTS = 2;
  localparam int unsigned IRQ_CODE = 3;
  // register request from software
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              we;
    logic              re;
  } rcil_bus_req_type;
  // reset scope handed to core and peripherals
  typedef struct packed {
    logic pc_clr;
    logic sp_top;
    logic sp_clr;
    logic int_dis;
    logic cnt_clr;
    logic tmr_off;
    logic port_in;
  } rcil_ctl_type;
  localparam rcil_ctl_type CTL_NONE  = '{1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
  localparam rcil_ctl_type CTL_FULL  = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1};
  localparam rcil_ctl_type CTL_SLEEP = '{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0};
  // sequencer states, one-hot
  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_FULL  = 4'b0010,
    ST_PCSP  = 4'b0100,
    ST_DELAY = 4'b1000
  } rcil_state_type;
endpackage
`default_nettype wire

//--- hw/rcil_reset_init.sv
// reset cause sequencer, flags, watchdog code check and register port
// Functional notes
// RULE1: power-on clears expiry and power-down flags
// RULE2: normal watchdog reset sets expiry, keeps power-down
// RULE3: sleep watchdog reset sets both flags
// RULE4: power-on forces all interrupt enables off
// RULE5: clear watchdog and time base, then count
// RULE6: power-on switches all timers off
// RULE7: power-on makes every port pin input
// RULE8: power-on sets stack pointer to top
// RULE9: each cause applies its own initial values
// RULE10: sleep watchdog reset clears only counter, stack
// RULE11: watchdog enable code powers up enabled
// RULE12: bad enable code resets after delay, flags
// RULE13: cause chosen from power, overflow, low-power
`default_nettype none
module rcil_reset_init #(
  parameter int unsigned RST_HOLD = 4,
  parameter int unsigned CNT_W    = 8
) (
  // clock and reset
  input  wire logic                       clk_i,
  input  wire logic                       arst_n_i,
  // register port
  input  wire rcil_pkg::rcil_bus_req_type bus_i,
  output logic [rcil_pkg::DATA_W-1:0]     bus_rdata_o,
  // reset sources
  input  wire logic                       por_i,
  input  wire logic                       wdt_ovf_i,
  input  wire logic                       lowpwr_i,
  // reset scope to core and peripherals
  output var rcil_pkg::rcil_ctl_type      ctl_o,
  output logic                            busy_o,
  // watchdog setup
  output logic                            wdt_en_o,
  output logic [2:0]                      wdt_sel_o,
  // interrupt
  output logic                            irq_o
);
  import rcil_pkg::*;

  // sequencer state and shared counter
  rcil_state_type       state;
  logic [CNT_W-1:0]     cnt;
  rcil_ctl_type         ctl;
  // flags and registers
  logic                 expiry_flag;     // watchdog expiry
  logic                 powerdown_flag;  // power-down
  logic [DATA_W-1:0]    wdog_ctl;        // watchdog control
  logic                 code_fault_flag; // code fault
  logic [IRQ_W-1:0]     irq_st;    // sticky events
  logic [IRQ_W-1:0]     irq_mask;  // interrupt enables
  logic [DATA_W-1:0]    rdata;
  // decoded events
  logic                 idle;
  logic                 code_bad;
  logic                 ev_wdtn;
  logic                 ev_wdts;
  logic                 ev_cflt;
  logic                 cnt_zero;
  logic [IRQ_W-1:0]     ev_vec;
  logic [IRQ_W-1:0]     w1c;
  logic                 wr_wdog_ctl;
  logic                 wr_rst_cause;
  logic                 wr_irq_st;
  logic                 wr_irq_mk;

  localparam logic [CNT_W-1:0] HOLD_LAST = CNT_W'(RST_HOLD - 1);
  localparam logic [CNT_W-1:0] DLY_LAST  = CNT_W'(SRESET_CYC - 1);
  localparam logic [CNT_W-1:0] CNT_ONE   = CNT_W'(1);

  // event decode
  assign idle     = (state == ST_IDLE);
  assign cnt_zero = (cnt == '0);
  // any pattern but enable or disable is a fault
  assign code_bad = (wdog_ctl[WE_HI:WE_LO] != WE_ENABLE) &&
                    (wdog_ctl[WE_HI:WE_LO] != WE_DISABLE); // RULE12
  // overflow split by low-power mode; ignored while disabled
  assign ev_wdtn  = wdt_ovf_i & ~lowpwr_i & idle & ~por_i & wdt_en_o; // RULE13
  assign ev_wdts  = wdt_ovf_i & lowpwr_i & idle & ~por_i & wdt_en_o; // RULE13
  // delay run out: the fault reset fires now
  assign ev_cflt  = (state == ST_DELAY) & cnt_zero & ~por_i; // RULE12

  // register strobes
  assign wr_wdog_ctl  = bus_i.we && (bus_i.addr == ADDR_WDOG_CTL);
  assign wr_rst_cause = bus_i.we && (bus_i.addr == ADDR_RST_CAUSE);
  assign wr_irq_st = bus_i.we && (bus_i.addr == ADDR_IRQ_ST);
  assign wr_irq_mk = bus_i.we && (bus_i.addr == ADDR_IRQ_MK);

  // sequencer: power-on wins from any state
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= ST_IDLE;
      cnt   <= '0;
    end else if (por_i) begin
      state <= ST_FULL;
      cnt   <= HOLD_LAST;
    end else begin
      case (state)
        ST_IDLE: begin
          if (ev_wdtn) begin
            // normal mode: same scope as power-on
            state <= ST_FULL; // RULE9
            cnt   <= HOLD_LAST;
          end else if (ev_wdts) begin
            state <= ST_PCSP; // RULE10
          end else if (code_bad) begin
            // noise hit the code; reset only after the delay
            state <= ST_DELAY; // RULE12
            cnt   <= DLY_LAST;
          end
        end
        ST_FULL: begin
          // hold the full scope for RST_HOLD cycles
          if (cnt_zero) begin
            state <= ST_IDLE;
          end else begin
            cnt <= cnt - CNT_ONE;
          end
        end
        ST_PCSP: begin
          // one-cycle counter and stack clear
          state <= ST_IDLE;
        end
        ST_DELAY: begin
          // a later fix of the code does not cancel the reset
          if (cnt_zero) begin
            state <= ST_FULL; // RULE12
            cnt   <= HOLD_LAST;
          end else begin
            cnt <= cnt - CNT_ONE;
          end
        end
        default: begin
          state <= ST_IDLE;
          cnt   <= '0;
        end
      endcase
    end
  end

  // reset scope outputs, registered
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      // async reset itself is a power-on: full scope
      ctl <= CTL_FULL; // RULE4
    end else if (por_i) begin
      // interrupts off, counters clear, timers off, pins input
      ctl <= CTL_FULL; // RULE4 RULE6 RULE7 RULE8
    end else begin
      case (state)
        ST_IDLE: begin
          if (ev_wdtn) begin
            ctl <= CTL_FULL; // RULE9
          end else if (ev_wdts) begin
            // only counter and stack; the rest keeps its state
            ctl <= CTL_SLEEP; // RULE10
          end else begin
            ctl <= CTL_NONE;
          end
        end
        ST_FULL: begin
          // release lets the watchdog start at once
          if (cnt_zero) begin
            ctl <= CTL_NONE; // RULE5
          end
        end
        ST_DELAY: begin
          ctl <= cnt_zero ? CTL_FULL : CTL_NONE;
        end
        default: begin
          ctl <= CTL_NONE;
        end
      endcase
    end
  end

  // expiry and power-down flags
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      expiry_flag    <= 1'b0; // RULE1
      powerdown_flag <= 1'b0;
    end else if (por_i) begin
      expiry_flag    <= 1'b0; // RULE1
      powerdown_flag <= 1'b0;
    end else if (ev_wdtn) begin
      // power-down flag left as it was
      expiry_flag <= 1'b1; // RULE2
    end else if (ev_wdts) begin
      expiry_flag    <= 1'b1; // RULE3
      powerdown_flag <= 1'b1;
    end
  end

  // watchdog control: reload on full-scope causes only
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wdog_ctl <= WDOG_CTL_POR; // RULE11
    end else if (por_i || ev_wdtn || ev_cflt) begin
      // sleep overflow leaves it untouched
      wdog_ctl <= WDOG_CTL_POR; // RULE9
    end else if (wr_wdog_ctl) begin
      wdog_ctl <= bus_i.wdata;
    end
  end

  // code fault flag: software may only clear it
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      code_fault_flag <= 1'b0;
    end else if (por_i) begin
      code_fault_flag <= 1'b0;
    end else if (ev_cflt) begin
      // set wins over a clearing write in the same cycle
      code_fault_flag <= 1'b1; // RULE12
    end else if (wr_rst_cause && !bus_i.wdata[RST_CAUSE_FAULT]) begin
      code_fault_flag <= 1'b0;
    end
  end

  // interrupt events and write-one-to-clear mask
  assign ev_vec = {ev_cflt, ev_wdts, ev_wdtn, por_i};
  assign w1c    = wr_irq_st ? bus_i.wdata[IRQ_W-1:0] : '0;

  // sticky status: set wins over clear
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_st <= '0;
    end else begin
      irq_st <= (irq_st & ~w1c) | ev_vec;
    end
  end

  // interrupt mask, dropped by power-on like every interrupt enable
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_mask <= '0;
    end else if (por_i) begin
      irq_mask <= '0; // RULE4
    end else if (wr_irq_mk) begin
      irq_mask <= bus_i.wdata[IRQ_W-1:0];
    end
  end

  // read data, valid only in the cycle after the strobe
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      rdata <= '0;
    end else if (bus_i.re) begin
      rdata <= '0;
      case (bus_i.addr)
        ADDR_STATUS: begin
          rdata[ST_EXPIRY] <= expiry_flag;
          rdata[ST_PWRDN]  <= powerdown_flag;
        end
        ADDR_WDOG_CTL: begin
          rdata <= wdog_ctl;
        end
        ADDR_RST_CAUSE: begin
          rdata[RST_CAUSE_FAULT] <= code_fault_flag;
        end
        ADDR_IRQ_ST: begin
          rdata[IRQ_W-1:0] <= irq_st;
        end
        ADDR_IRQ_MK: begin
          rdata[IRQ_W-1:0] <= irq_mask;
        end
        default: begin
          // unmapped reads return zero
          rdata <= '0;
        end
      endcase
    end else begin
      rdata <= '0;
    end
  end

  // outputs
  assign bus_rdata_o = rdata;
  assign ctl_o       = ctl;
  assign busy_o      = !idle;
  assign wdt_en_o    = (wdog_ctl[WE_HI:WE_LO] == WE_ENABLE);
  assign wdt_sel_o   = wdog_ctl[WS_HI:WS_LO];
  assign irq_o       = |(irq_st & irq_mask);

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!arst_n_i);

  chk_por_flags: assert property ( // RULE1
    por_i |=> !expiry_flag && !powerdown_flag && !code_fault_flag)
    else $error("power-on left a reset flag set");

  chk_wdt_normal: assert property ( // RULE2
    ev_wdtn |=> expiry_flag && (powerdown_flag == $past(powerdown_flag)))
    else $error("normal watchdog reset flags wrong");

  chk_wdt_sleep: assert property ( // RULE3
    ev_wdts |=> expiry_flag && powerdown_flag)
    else $error("sleep watchdog reset flags wrong");

  chk_int_disable: assert property ( // RULE4
    por_i |=> ctl_o.int_dis && ctl_o.pc_clr && (irq_mask == '0))
    else $error("interrupts not disabled after power-on");

  chk_wdt_restart: assert property ( // RULE5
    (state == ST_FULL) && cnt_zero && !por_i |=>
      !ctl_o.cnt_clr && wdt_en_o && idle)
    else $error("watchdog not released to count");

  chk_timer_off: assert property ( // RULE6
    (state == ST_FULL) |-> ctl_o.tmr_off && ctl_o.cnt_clr)
    else $error("timers not held off in full reset");

  chk_port_input: assert property ( // RULE7
    (state == ST_FULL) |-> ctl_o.port_in && !ctl_o.sp_clr)
    else $error("port pins not held as inputs");

  chk_stack_top: assert property ( // RULE8
    por_i |=> ctl_o.sp_top [*2])
    else $error("stack pointer not set to top");

  chk_ctl_reload: assert property ( // RULE9
    ev_wdtn |=> (wdog_ctl == WDOG_CTL_POR) && (state == ST_FULL))
    else $error("normal watchdog reset skipped reload");

  chk_sleep_scope: assert property ( // RULE10
    ev_wdts |=> (ctl_o == CTL_SLEEP) && $stable(wdog_ctl) ##1 (ctl_o == CTL_NONE))
    else $error("sleep watchdog reset scope wrong");

  chk_code_enable: assert property ( // RULE11
    por_i |=> (wdog_ctl[WE_HI:WE_LO] == WE_ENABLE))
    else $error("enable code not restored at power-on");

  chk_code_fault: assert property ( // RULE12
    idle && code_bad && !por_i && !ev_wdtn && !ev_wdts |=>
      (state == ST_DELAY) ##[1:300] (code_fault_flag && (state == ST_FULL)))
    else $error("bad enable code did not reset with flag");

  chk_cause_select: assert property ( // RULE13
    ev_wdts |=> (state == ST_PCSP) ##1 idle)
    else $error("low-power overflow took wrong scope");

  chk_irq_set_wins: assert property (
    ev_vec[IRQ_POR] && w1c[IRQ_POR] |=> irq_st[IRQ_POR])
    else $error("event lost against clear");
endmodule
`default_nettype wire

//--- dv/rcil_core_model.sv
// behavioural core and peripheral model that obeys the reset scope
`default_nettype none
module rcil_core_model (
  // clock and reset
  input  wire logic                   clk_i,
  input  wire logic                   arst_n_i,
  // reset scope and software switch-on
  input  wire rcil_pkg::rcil_ctl_type ctl_i,
  input  wire logic                   sw_on_i,
  // observed core and peripheral state
  output logic [7:0]                  pc_o,
  output logic [2:0]                  sp_o,
  output logic                        int_en_o,
  output logic                        tmr_on_o,
  output logic                        port_out_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import rcil_pkg::*;
  // program counter runs freely unless held clear
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pc_o <= 8'h00;
    end else if (ctl_i.pc_clr) begin
      pc_o <= 8'h00;
    end else begin
      pc_o <= pc_o + 8'h01;
    end
  end
  // stack pointer: top on full scope, zero on sleep scope
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sp_o <= 3'h7;
    end else if (ctl_i.sp_top) begin
      sp_o <= 3'h7;
    end else if (ctl_i.sp_clr) begin
      sp_o <= 3'h0;
    end
  end
  // enables stay on across a sleep reset, so scope must force them off
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      int_en_o   <= 1'b0;
      tmr_on_o   <= 1'b0;
      port_out_o <= 1'b0;
    end else begin
      int_en_o   <= !ctl_i.int_dis && (int_en_o || sw_on_i);
      tmr_on_o   <= !ctl_i.tmr_off && (tmr_on_o || sw_on_i);
      port_out_o <= !ctl_i.port_in && (port_out_o || sw_on_i);
    end
  end
endmodule
`default_nettype wire

//--- dv/rcil_reset_init_tb_top.sv
// directed testbench for the reset initial condition logic
`default_nettype none
module rcil_reset_init_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import rcil_pkg::*;
  localparam int unsigned HOLD = 4; // short full-scope hold
  logic clk_i, arst_n_i, por_i, wdt_ovf_i, lowpwr_i, sw_on;
  rcil_bus_req_type  bus_i;   // register request
  logic [DATA_W-1:0] rdata;   // read data
  rcil_ctl_type      ctl;     // reset scope
  logic              busy, wdt_en, irq, int_en, tmr_on, port_out;
  logic [2:0]        wdt_sel, sp;
  logic [7:0]        pc;
  int                n_fail, checked, n;
  rcil_reset_init #(.RST_HOLD(HOLD), .CNT_W(8)) dut (.clk_i(clk_i), .arst_n_i(arst_n_i),
    .bus_i(bus_i), .bus_rdata_o(rdata), .por_i(por_i), .wdt_ovf_i(wdt_ovf_i),
    .lowpwr_i(lowpwr_i), .ctl_o(ctl), .busy_o(busy), .wdt_en_o(wdt_en),
    .wdt_sel_o(wdt_sel), .irq_o(irq));
  rcil_core_model u_core (.clk_i(clk_i), .arst_n_i(arst_n_i), .ctl_i(ctl), .sw_on_i(sw_on),
    .pc_o(pc), .sp_o(sp), .int_en_o(int_en), .tmr_on_o(tmr_on), .port_out_o(port_out));
  // 100 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // shared compare
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    checked++;
    if (exp !== got) begin
      n_fail++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // settle point one step after an edge
  task automatic cyc(int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask
  // single-cycle register write
  task automatic wr(logic [2:0] a, logic [7:0] d);
    @(posedge clk_i);
    bus_i.we    <= 1'b1;
    bus_i.addr  <= a;
    bus_i.wdata <= d;
    @(posedge clk_i);
    bus_i.we <= 1'b0;
  endtask
  // single-cycle read, data stands in the following cycle
  task automatic rd(logic [2:0] a, logic [7:0] e, string what);
    @(posedge clk_i);
    bus_i.re   <= 1'b1;
    bus_i.addr <= a;
    @(posedge clk_i);
    bus_i.re <= 1'b0;
    #1;
    chk(what, e, rdata);
  endtask
  // one-cycle reset source request, returns when scope has answered
  task automatic src(logic p, logic o, logic lp);
    @(posedge clk_i);
    por_i     <= p;
    wdt_ovf_i <= o;
    lowpwr_i  <= lp;
    @(posedge clk_i);
    por_i     <= 1'b0;
    wdt_ovf_i <= 1'b0;
    #1;
  endtask
  // software switches interrupts, timers and port outputs on
  task automatic sw_pulse();
    @(posedge clk_i);
    sw_on <= 1'b1;
    @(posedge clk_i);
    sw_on <= 1'b0;
  endtask
  // power-on with everything switched on beforehand
  task automatic power_on();
    sw_pulse();
    src(1'b1, 1'b0, 1'b0);
    chk("ctl_por", {1'b0, CTL_FULL}, {1'b0, ctl});
    cyc(HOLD - 1);
    chk("core_por", 8'h38, {2'b00, sp, int_en, tmr_on, port_out});
    chk("pc_por", 8'h00, pc);
    cyc(1);
    chk("ctl_end", 8'h00, {busy, ctl});
    rd(ADDR_STATUS, 8'h00, "status_por");
    rd(ADDR_IRQ_MK, 8'h00, "mask_por");
    rd(ADDR_RST_CAUSE, 8'h00, "cause_por");
  endtask
  // verdict
  task automatic report_and_stop();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // hang guard, far beyond the few hundred cycles the tests need
  initial begin
    #200000;
    n_fail++;
    report_and_stop();
  end
  // main sequence
  initial begin
    arst_n_i  = 1'b0;
    por_i     = 1'b0;
    wdt_ovf_i = 1'b0;
    lowpwr_i  = 1'b0;
    sw_on     = 1'b0;
    bus_i     = '0;
    n_fail    = 0;
    checked   = 0;
    repeat (2) @(posedge clk_i);
    arst_n_i <= 1'b1;
    cyc(1);
    chk("wdt_setup", 8'h0B, {4'h0, wdt_en, wdt_sel});
    rd(ADDR_WDOG_CTL, WDOG_CTL_POR, "wdog_ctl_rst");
    rd(3'h5, 8'h00, "unmapped");
    power_on();
    wr(ADDR_IRQ_MK, 8'h0F);
    cyc(1);
    chk("irq_por", 8'h01, {7'h00, irq});
    wr(ADDR_IRQ_ST, 8'h01);
    cyc(1);
    chk("irq_clr", 8'h00, {7'h00, irq});
    // normal overflow reloads watchdog control, keeps power-down flag
    wr(ADDR_WDOG_CTL, 8'h52);
    src(1'b0, 1'b1, 1'b0);
    chk("ctl_norm", {1'b0, CTL_FULL}, {1'b0, ctl});
    cyc(HOLD);
    chk("ctl_norm_end", 8'h00, {busy, ctl});
    rd(ADDR_STATUS, 8'h02, "status_norm");
    rd(ADDR_WDOG_CTL, 8'h53, "wdog_ctl_norm");
    chk("irq_norm", 8'h01, {7'h00, irq});
    wr(ADDR_IRQ_MK, 8'h0D);
    cyc(1);
    chk("irq_masked", 8'h00, {7'h00, irq});
    wr(ADDR_IRQ_ST, 8'h02);
    wr(ADDR_IRQ_MK, 8'h0F);
    // sleep overflow touches only counter and stack
    sw_pulse();
    wr(ADDR_WDOG_CTL, 8'h52);
    src(1'b0, 1'b1, 1'b1);
    chk("ctl_sleep", {1'b0, CTL_SLEEP}, {1'b0, ctl});
    cyc(1);
    chk("ctl_sleep_end", 8'h00, {busy, ctl});
    chk("core_sleep", 8'h07, {2'b00, sp, int_en, tmr_on, port_out});
    chk("pc_sleep", 8'h00, pc);
    rd(ADDR_STATUS, 8'h03, "status_sleep");
    rd(ADDR_WDOG_CTL, 8'h52, "wdog_ctl_sleep");
    src(1'b0, 1'b1, 1'b0);
    cyc(HOLD);
    rd(ADDR_STATUS, 8'h03, "status_keep_pdf");
    // disable code: no fault, overflow ignored
    wr(ADDR_WDOG_CTL, 8'hAB);
    cyc(1);
    chk("wdt_dis", 8'h00, {7'h00, wdt_en});
    src(1'b0, 1'b1, 1'b0);
    chk("ovf_dis", 8'h00, {busy, ctl});
    rd(ADDR_RST_CAUSE, 8'h00, "cause_dis");
    // bad code: delayed full reset and fault flag
    wr(ADDR_WDOG_CTL, 8'hFB);
    for (n = 0; n < SRESET_CYC + 20 && ctl !== CTL_FULL; n++) begin
      cyc(1);
    end
    // one cycle to notice the bad code, then the whole delay
    chk("fault_delay", 8'h01, {7'h00, (n == SRESET_CYC + 1)});
    chk("ctl_fault", {1'b0, CTL_FULL}, {1'b0, ctl});
    cyc(HOLD);
    rd(ADDR_RST_CAUSE, 8'h01, "cause_fault");
    rd(ADDR_WDOG_CTL, 8'h53, "wdog_ctl_fault");
    rd(ADDR_IRQ_ST, 8'h0E, "irq_st");
    wr(ADDR_RST_CAUSE, 8'h00);
    rd(ADDR_RST_CAUSE, 8'h00, "cause_clr");
    // second power-on clears set flags
    power_on();
    // power-on event and a clearing write in one cycle: the event stays
    @(posedge clk_i);
    por_i       <= 1'b1;
    bus_i.we    <= 1'b1;
    bus_i.addr  <= ADDR_IRQ_ST;
    bus_i.wdata <= 8'h0F;
    @(posedge clk_i);
    por_i    <= 1'b0;
    bus_i.we <= 1'b0;
    cyc(HOLD);
    rd(ADDR_IRQ_ST, 8'h01, "irq_set_wins");
    report_and_stop();
  end
endmodule
`default_nettype wire
